// ===== sim/dcm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// watches the bus answer, the reference enable, the derived outputs of channel 0 and the feedback isolation of every channel
module dcm_checker #(
  parameter int NCH = 2,
  parameter int CODE_W = 12
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [2*NCH-1:0] o_mode,
  input wire logic [2*NCH-1:0] o_ref_sel,
  input wire logic [3*NCH-1:0] o_gain,
  input wire logic [2*NCH-1:0] o_cmp_behaviour,
  input wire logic [NCH-1:0] o_cmp_invalid,
  input wire logic [NCH-1:0] o_feedback_pin_hiz,
  input wire logic o_int_ref_en,
  input wire logic [NCH-1:0] o_cmp_pin_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // one wait-free access: a stuck slave would hang software
  ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  idle_rdata_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  // the enable lands one edge after the access edge, so it is sampled two cycles later
  intref_write_a: assert property (i_psel && i_penable && i_pwrite
    && o_pready && i_paddr == 8'h00 |-> ##2 o_int_ref_en == $past(i_pwdata[12], 2))
    else $error("reference enable not updated");
  ext_unity_a: assert property (o_ref_sel[1:0] == 2'h0 |-> o_gain[2:0] == 3'h0)
    else $error("gain not unity on external");
  vdd_unity_a: assert property (o_ref_sel[1:0] == 2'h1 |-> o_gain[2:0] == 3'h1)
    else $error("gain not unity on supply");
  pin_idle_a: assert property (o_mode[1:0] != 2'h3 |-> o_cmp_pin_oe_n[0])
    else $error("pin driven outside comparator");
  bad_mode_a: assert property (o_cmp_behaviour[1:0] == 2'h3
    && $stable(o_cmp_behaviour) |-> o_cmp_invalid[0])
    else $error("invalid behaviour not flagged");
  hiz_reset_a: assert property ($fell(i_sys_rst) |-> &o_feedback_pin_hiz)
    else $error("feedback input not hi-z");
  cover property (o_mode[1:0] == 2'h3);
  cover property (o_mode[3:2] == 2'h2);
  cover property (o_pslverr);
endmodule : dcm_checker
bind dcm_top dcm_checker #(.NCH(NCH), .CODE_W(CODE_W)) u_chk (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_mode(o_mode), .o_ref_sel(o_ref_sel), .o_gain(o_gain),
  .o_cmp_behaviour(o_cmp_behaviour), .o_cmp_invalid(o_cmp_invalid),
  .o_feedback_pin_hiz(o_feedback_pin_hiz), .o_int_ref_en(o_int_ref_en),
  .o_cmp_pin_oe_n(o_cmp_pin_oe_n));
`default_nettype wire

// ===== sim/dcm_load.sv
`timescale 1ns/1ps
`default_nettype none
// analog side: sensed feedback level and the pull-up on the comparator pins
module dcm_load (
  input wire logic i_level,
  input wire logic [1:0] i_pin_out,
  input wire logic [1:0] i_pin_oe_n,
  output logic [1:0] o_cmp_raw,
  output logic [1:0] o_pin_level
);
  // one shared level keeps stimulus small; channels are not told apart here
  assign o_cmp_raw = {2{i_level}};
  // a released pin floats up through the external resistor
  assign o_pin_level = i_pin_oe_n | i_pin_out;
endmodule : dcm_load
`default_nettype wire

// ===== sim/dcm_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dcm_top_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic lvl = 1'b0;
  logic e;
  logic pready;
  logic pslverr;
  logic ire;
  logic mdis;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] q;
  logic [31:0] prdata;
  logic [1:0] raw, oe_n, pout, pin, inv, hiz;
  logic [3:0] mode, rsel, beh;
  logic [5:0] gain;
  logic [23:0] vc;
  logic [15:0] cc;
  logic [7:0] rng;
  int num_errors = 0;
  int compares = 0;
  // free-running 20 MHz reference
  always #25 ref_clk = ~ref_clk;
  dcm_top i_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cmp_raw(raw),
    .o_mode(mode), .o_ref_sel(rsel), .o_gain(gain), .o_volt_code(vc), .o_curr_code(cc),
    .o_curr_range(rng), .o_cmp_behaviour(beh), .o_cmp_invalid(inv),
    .o_feedback_pin_hiz(hiz), .o_int_ref_en(ire), .o_mode_input_disable(mdis),
    .o_cmp_pin_out(pout), .o_cmp_pin_oe_n(oe_n));
  dcm_load i_load (.i_level(lvl), .i_pin_out(pout), .i_pin_oe_n(oe_n),
    .o_cmp_raw(raw), .o_pin_level(pin));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // one apb transfer; request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    // an idle edge first, so back-to-back calls never drive psel twice at one instant
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      chk("ready", 32'h0, 32'h1);
  endtask : apb
  // derived outputs and the pin trail the write by one edge; a comparator level change reaches the pin in three
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (4) @(posedge ref_clk);
  endtask : wr
  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, 8'h00, 32'h0);
    chk("common", q, 32'h00000f0f);
    chk("ref", {rsel, mode, 1'b0, ire}, 32'h0);
    chk("hiz", {oe_n, hiz}, 32'hf);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", q, 32'h0);
    $display("test reset done");
    wr(8'h00, 32'h00001f0c);
    chk("volt", {ire, mode[1:0]}, 32'h5);
    // codes 6 and 7 must fall back to the external reference at unity gain
    for (int g = 0; g < 8; g++)
    begin
      wr(8'h10, g);
      chk("gain", gain[2:0], (g > 5) ? 3'h0 : 3'(g));
      chk("rsel", rsel[1:0], (g == 0 || g > 5) ? 2'h0 : (g == 1) ? 2'h1 : 2'h2);
    end
    wr(8'h1c, 32'h0000fff0);
    chk("vcode", vc[11:0], 12'hfff);
    wr(8'h24, 32'h0);
    wr(8'h00, 32'h00001d0c);
    wr(8'h2c, 32'h0000ab00);
    wr(8'h24, 32'h9);
    chk("curr", {mode[3:2], cc[15:8], rng[7:4]}, {2'h2, 8'hab, 4'h9});
    wr(8'h20, 32'h30);
    chk("curr cmp", {mode[3:2], oe_n[1]}, 3'h5);
    apb(1'b0, 8'h08, 32'h0);
    chk("status", q, 32'h9);
    apb(1'b0, 8'h24, 32'h0);
    chk("range read", q, 32'h9);
    $display("test modes done");
    for (int k = 0; k < 32; k++)
    begin
      logic en, oe, od, iv, r, t;
      {r, iv, od, oe, en} = k[4:0];
      t = r ^ iv;
      lvl <= r;
      wr(8'h10, {24'h0, iv, od, oe, en, 4'h2});
      chk("mode", mode[1:0], en ? 2'h3 : 2'h1);
      chk("pin", {oe_n[0], pout[0] & ~oe_n[0]},
        (en & oe) ? (od ? {t, 1'b0} : {1'b0, t}) : 2'h2);
      chk("level", pin[0], (en & oe) ? t : 1'b1);
    end
    wr(8'h10, 32'h102);
    chk("hizdis", hiz, 2'h2);
    $display("test comparator done");
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h18, b);
      wr(8'h28, 3 - b);
      chk("beh", beh, {2'(3 - b), 2'(b)});
      chk("inv", inv, {b == 0, b == 3});
    end
    wr(8'h04, 32'h1);
    chk("mdis", mdis, 1'b1);
    $display("test behaviour done");
    // reset in mid-run must drop the reference and re-isolate the feedback inputs
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("rerun reset", {ire, mdis, hiz}, 32'h3);
    apb(1'b0, 8'h00, 32'h0);
    chk("rerun common", q, 32'h00000f0f);
    $display("test mid reset done");
    complete_run();
  end
endmodule : dcm_top_test
`default_nettype wire

// ===== src/dcm_pkg.sv
// Function
// - vout power-up plus iout down gives voltage mode
// - internal reference off until enable written 1
// - internal reference gain 1.5x 2x 3x 4x
// - voltage code 10 or 12 bits wide
// - external reference after reset, always at unity gain
// - external reference forces unity gain
// - supply reference forces unity gain
// - reference sets voltage and comparator transfer
// - iout enabled plus vout hi-z gives current mode
// - current range follows range select field
// - current mode code is 8 bits
// - comparator only in voltage mode when enabled
// - open drain select picks push-pull or open-drain
// - pin drive enable gates comparator output
// - invert bit inverts pin comparator result
// - feedback input hi-z until disable bit set
// - behaviour select per channel plain/hyst/window
// - behaviour 00 plain 01 hyst 10 window 11 bad
package dcm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_COMMON = 8'h00;
  localparam logic [7:0] ADDR_DEVMODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam int CH_STRIDE = 16;
  localparam logic [7:0] OFS_VCMP = 8'h00;
  localparam logic [7:0] OFS_IMISC = 8'h04;
  localparam logic [7:0] OFS_CMODE = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  // common register fields: per channel vout pdn at 2*ch, iout pdn at 8+ch
  localparam int COM_VPDN_LSB = 0;
  localparam int COM_IPDN_LSB = 8;
  localparam int COM_INTREF_BIT = 12;
  localparam logic [1:0] VPDN_UP = 2'h0;
  localparam logic [1:0] VPDN_HIZ = 2'h3;
  localparam logic [31:0] COMMON_RST = 32'h00000f0f;
  // voltage/comparator config fields
  localparam int VC_GAIN_LSB = 0;
  localparam int VC_EN_BIT = 4;
  localparam int VC_OUTEN_BIT = 5;
  localparam int VC_OD_BIT = 6;
  localparam int VC_INV_BIT = 7;
  localparam int VC_HIZDIS_BIT = 8;
  localparam logic [31:0] VCMP_RST = 32'h00000000;
  // gain select codes
  localparam logic [2:0] GAIN_EXT = 3'h0;
  localparam logic [2:0] GAIN_VDD = 3'h1;
  localparam logic [2:0] GAIN_1P5 = 3'h2;
  localparam logic [2:0] GAIN_2 = 3'h3;
  localparam logic [2:0] GAIN_3 = 3'h4;
  localparam logic [2:0] GAIN_4 = 3'h5;
  localparam int DEVMODE_DIS_BIT = 0;
  localparam int RANGE_W = 4;
  localparam int CMODE_W = 2;
  localparam logic [1:0] CMODE_PLAIN = 2'h0;
  localparam logic [1:0] CMODE_HYST = 2'h1;
  localparam logic [1:0] CMODE_WIN = 2'h2;
  localparam logic [1:0] CMODE_BAD = 2'h3;
  typedef enum logic [1:0] {DCM_OFF, DCM_VOLT, DCM_CURR, DCM_CMP} dcm_mode_e;
  typedef enum logic [1:0] {DCM_REF_EXT, DCM_REF_VDD, DCM_REF_INT} dcm_ref_e;
endpackage : dcm_pkg

// ===== src/dcm_top.sv
`timescale 1ns/1ps
`default_nettype none
// per-channel mode, reference, gain and comparator pin control behind apb
module dcm_top #(
  parameter int NCH = 2,
  parameter int CODE_W = 12
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NCH-1:0] i_cmp_raw,
  output logic [2*NCH-1:0] o_mode,
  output logic [2*NCH-1:0] o_ref_sel,
  output logic [3*NCH-1:0] o_gain,
  output logic [CODE_W*NCH-1:0] o_volt_code,
  output logic [8*NCH-1:0] o_curr_code,
  output logic [4*NCH-1:0] o_curr_range,
  output logic [2*NCH-1:0] o_cmp_behaviour,
  output logic [NCH-1:0] o_cmp_invalid,
  output logic [NCH-1:0] o_feedback_pin_hiz,
  output logic o_int_ref_en,
  output logic o_mode_input_disable,
  output logic [NCH-1:0] o_cmp_pin_out,
  output logic [NCH-1:0] o_cmp_pin_oe_n
);
  // refuse sizes that the address map and code slicing cannot serve
  if (NCH < 1 || NCH > 4)
  begin : g_bad_nch
    $error("NCH must be 1 to 4");
  end
  if (CODE_W != 10 && CODE_W != 12)
  begin : g_bad_code_w
    $error("CODE_W must be 10 or 12");
  end

  logic [31:0] common_r;
  logic mode_in_dis_r;
  logic [8:0] vcmp_r [NCH];
  logic [3:0] range_r [NCH];
  logic [1:0] cmode_r [NCH];
  logic [15:0] data_r [NCH];
  logic [NCH-1:0] cmp_s1_r;
  logic [NCH-1:0] cmp_s2_r;
  logic wr_en;
  logic [31:0] rd_nxt;
  logic hit_nxt;
  logic [NCH-1:0] sel_vcmp;
  logic [NCH-1:0] sel_imisc;
  logic [NCH-1:0] sel_cmode;
  logic [NCH-1:0] sel_data;

  // apb answers in the access cycle: zero wait states
  assign wr_en = i_psel && i_penable && i_pwrite;

  // per-channel address match, shared by the write and read paths
  for (genvar c = 0; c < NCH; c++)
  begin : g_sel
    localparam logic [7:0] BASE = 8'(dcm_pkg::ADDR_CH_BASE + c * dcm_pkg::CH_STRIDE);
    assign sel_vcmp[c] = i_paddr == 8'(BASE + dcm_pkg::OFS_VCMP);
    assign sel_imisc[c] = i_paddr == 8'(BASE + dcm_pkg::OFS_IMISC);
    assign sel_cmode[c] = i_paddr == 8'(BASE + dcm_pkg::OFS_CMODE);
    assign sel_data[c] = i_paddr == 8'(BASE + dcm_pkg::OFS_DATA);
  end

  // comparator inputs come from the analog side, so resample twice
  // only the second stage is read, so a metastable first stage never reaches logic
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      cmp_s1_r <= '0;
      cmp_s2_r <= '0;
    end
    else
    begin
      cmp_s1_r <= i_cmp_raw;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // shared registers; reset leaves internal ref off and the outputs of channels 0 and 1 hi-z
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      common_r <= dcm_pkg::COMMON_RST;
      mode_in_dis_r <= 1'b0;
    end
    else if (wr_en && i_paddr == dcm_pkg::ADDR_COMMON)
      common_r <= i_pwdata;
    else if (wr_en && i_paddr == dcm_pkg::ADDR_DEVMODE)
      mode_in_dis_r <= i_pwdata[dcm_pkg::DEVMODE_DIS_BIT];
  end

  // per-channel registers, one word group per channel
  // a write takes effect at the access edge; no second trigger is needed
  always_ff @(posedge i_ref_clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (i_sys_rst)
      begin
        vcmp_r[c] <= dcm_pkg::VCMP_RST[8:0];
        range_r[c] <= '0;
        cmode_r[c] <= dcm_pkg::CMODE_PLAIN;
        data_r[c] <= '0;
      end
      else if (wr_en)
      begin
        if (sel_vcmp[c])
          vcmp_r[c] <= i_pwdata[8:0];
        if (sel_imisc[c])
          range_r[c] <= i_pwdata[dcm_pkg::RANGE_W-1:0];
        if (sel_cmode[c])
          cmode_r[c] <= i_pwdata[dcm_pkg::CMODE_W-1:0];
        if (sel_data[c])
          data_r[c] <= i_pwdata[15:0];
      end
    end
  end

  // read decode; unmapped addresses answer zero with pslverr
  // the decode runs in the setup cycle; its result is registered for the access
  always_comb
  begin
    rd_nxt = '0;
    hit_nxt = 1'b0;
    case (i_paddr)
      dcm_pkg::ADDR_COMMON:
      begin
        rd_nxt = common_r;
        hit_nxt = 1'b1;
      end
      dcm_pkg::ADDR_DEVMODE:
      begin
        rd_nxt = {31'h0, mode_in_dis_r};
        hit_nxt = 1'b1;
      end
      dcm_pkg::ADDR_STATUS:
      begin
        rd_nxt = 32'(o_mode); // status shows every channel's mode
        hit_nxt = 1'b1;
      end
      default:
      begin
        for (int c = 0; c < NCH; c++)
        begin
          if (sel_vcmp[c])
          begin
            rd_nxt = {23'h0, vcmp_r[c]};
            hit_nxt = 1'b1;
          end
          if (sel_imisc[c])
          begin
            rd_nxt = {28'h0, range_r[c]};
            hit_nxt = 1'b1;
          end
          if (sel_cmode[c])
          begin
            rd_nxt = {30'h0, cmode_r[c]};
            hit_nxt = 1'b1;
          end
          if (sel_data[c])
          begin
            rd_nxt = {16'h0, data_r[c]};
            hit_nxt = 1'b1;
          end
        end
      end
    endcase
  end

  // bus answer registers
  // ready is the registered setup cycle, so every access has one wait-free phase
  // read data is zero outside a read answer so stale words never leak onto the bus
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !hit_nxt;
      o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rd_nxt : 32'h0;
    end
  end

  // channel decode: mode, reference, gain, codes and comparator pin
  always_ff @(posedge i_ref_clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      logic [1:0] vp;
      logic ip;
      logic [2:0] g;
      logic cres;
      vp = common_r[dcm_pkg::COM_VPDN_LSB + 2*c +: 2];
      ip = common_r[dcm_pkg::COM_IPDN_LSB + c];
      g = vcmp_r[c][dcm_pkg::VC_GAIN_LSB +: 3];
      cres = cmp_s2_r[c] ^ vcmp_r[c][dcm_pkg::VC_INV_BIT];
      // reset: outputs off, external reference, pin released, feedback isolated
      if (i_sys_rst)
      begin
        o_mode[2*c +: 2] <= 2'(dcm_pkg::DCM_OFF);
        o_ref_sel[2*c +: 2] <= 2'(dcm_pkg::DCM_REF_EXT);
        o_gain[3*c +: 3] <= dcm_pkg::GAIN_EXT;
        o_volt_code[CODE_W*c +: CODE_W] <= '0;
        o_curr_code[8*c +: 8] <= '0;
        o_curr_range[4*c +: 4] <= '0;
        o_cmp_behaviour[2*c +: 2] <= dcm_pkg::CMODE_PLAIN;
        o_cmp_invalid[c] <= 1'b0;
        o_feedback_pin_hiz[c] <= 1'b1;
        o_cmp_pin_out[c] <= 1'b0;
        o_cmp_pin_oe_n[c] <= 1'b1;
      end
      else
      begin
        // voltage mode, comparator needs voltage mode too
        if (vp == dcm_pkg::VPDN_UP && ip)
          o_mode[2*c +: 2] <= vcmp_r[c][dcm_pkg::VC_EN_BIT] ?
            2'(dcm_pkg::DCM_CMP) : 2'(dcm_pkg::DCM_VOLT);
        else if (vp == dcm_pkg::VPDN_HIZ && !ip)
          o_mode[2*c +: 2] <= 2'(dcm_pkg::DCM_CURR);
        // any other pairing of the two power-down controls leaves the channel off
        else
          o_mode[2*c +: 2] <= 2'(dcm_pkg::DCM_OFF);
        // reference picks the transfer for voltage and comparator use
        // gain codes 6 and 7 are unused and fall back to the external reference
        if (g == dcm_pkg::GAIN_EXT || g > dcm_pkg::GAIN_4)
        begin
          o_ref_sel[2*c +: 2] <= 2'(dcm_pkg::DCM_REF_EXT);
          o_gain[3*c +: 3] <= dcm_pkg::GAIN_EXT;
        end
        else if (g == dcm_pkg::GAIN_VDD)
        begin
          o_ref_sel[2*c +: 2] <= 2'(dcm_pkg::DCM_REF_VDD);
          o_gain[3*c +: 3] <= dcm_pkg::GAIN_VDD;
        end
        else
        begin
          o_ref_sel[2*c +: 2] <= 2'(dcm_pkg::DCM_REF_INT);
          o_gain[3*c +: 3] <= g;
        end
        // 16-bit data word is left aligned, as the code width varies
        o_volt_code[CODE_W*c +: CODE_W] <= data_r[c][15 -: CODE_W];
        // current mode keeps only the upper byte: its code is eight bits wide
        o_curr_code[8*c +: 8] <= data_r[c][15:8];
        o_curr_range[4*c +: 4] <= range_r[c];
        o_cmp_behaviour[2*c +: 2] <= cmode_r[c];
        o_cmp_invalid[c] <= cmode_r[c] == dcm_pkg::CMODE_BAD;
        o_feedback_pin_hiz[c] <= !vcmp_r[c][dcm_pkg::VC_HIZDIS_BIT];
        // pin drive only when comparator active and drive enabled
        if (vp == dcm_pkg::VPDN_UP && ip && vcmp_r[c][dcm_pkg::VC_EN_BIT]
            && vcmp_r[c][dcm_pkg::VC_OUTEN_BIT])
        begin
          // open drain releases the pin for a high result; the pull-up sets the level
          if (vcmp_r[c][dcm_pkg::VC_OD_BIT])
          begin
            o_cmp_pin_out[c] <= 1'b0;
            o_cmp_pin_oe_n[c] <= cres;
          end
          else
          begin
            o_cmp_pin_out[c] <= cres;
            o_cmp_pin_oe_n[c] <= 1'b0;
          end
        end
        else
        begin
          o_cmp_pin_out[c] <= 1'b0;
          o_cmp_pin_oe_n[c] <= 1'b1;
        end
      end
    end
  end

  // common-level outputs
  // the reference stays off until software sets its enable; reset never turns it on
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_int_ref_en <= 1'b0;
      o_mode_input_disable <= 1'b0;
    end
    else
    begin
      o_int_ref_en <= common_r[dcm_pkg::COM_INTREF_BIT];
      o_mode_input_disable <= mode_in_dis_r;
    end
  end
endmodule : dcm_top
`default_nettype wire
